// file: src/cics_dev.sv
// codec-side power-down, init, resync and calibration sequencer
`timescale 1ns/1ps
module cics_dev
	import cics_pkg::*;
#(
	parameter int INIT_N   = INIT_CYC,
	parameter int RESYNC_N = RESYNC_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_b,
	cics_link_if.dev         lnk,
	input  wire logic [15:0] i_play_data,
	input  wire logic        i_play_valid,
	input  wire logic [15:0] i_adc_offset,
	output logic      [15:0] o_dac_data,
	output logic             o_dac_mute,
	output logic             o_capture_valid,
	output logic             o_xfer_go,
	output logic      [15:0] o_offset,
	output logic             o_analog_en,
	output logic             o_sample_tick
);
	cics_dev_st_t state_r;
	cics_cal_st_t cal_r;
	logic [15:0]  tmr_r;
	logic [8:0]   cal_cnt_r;
	logic         rate_chg_r;
	logic         wr_prev_r;
	logic         wsel_r;
	logic [7:0]   wdat_r;
	logic [1:0]   wadr_r;
	logic [3:0]   index_r;
	logic         mce_r;
	logic [7:0]   ctrl_r [16];
	logic [7:0]   rd_r;
	logic         oe_r;
	logic         pd;
	logic         wr_ok;
	logic         clk_chg;
	logic         mce_fall;
	logic         autocal_in_progress;
	logic         cal_idle;
	logic         run;
	logic         cal_end;
	logic [8:0]   cal_last;

	assign pd       = !lnk.power_down_n;
	assign run      = state_r == DV_RUN;
	assign autocal_in_progress      = cal_r == CL_RUN;
	assign cal_idle = cal_r == CL_IDLE;
	// a write counts on the rising edge of the write strobe
	assign wr_ok    = lnk.wr_n && !wr_prev_r && wsel_r && run;
	assign clk_chg  = wr_ok && wadr_r == A_DATA && index_r == R_FMT
		&& mce_r && wdat_r[3:0] != ctrl_r[R_FMT][3:0];
	assign mce_fall = wr_ok && wadr_r == A_INDEX && mce_r
		&& !wdat_r[IDX_MCE_BIT];
	assign cal_last = rate_chg_r ? CAL_RATE_SP : CAL_FULL_SP;
	assign cal_end  = autocal_in_progress && o_sample_tick
		&& cal_cnt_r == cal_last - 9'h001;

	// ----------------------------------------------------------------
	// power and init state
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_r <= DV_OFF;
			tmr_r   <= '0;
		end else if (pd) begin
			state_r <= DV_OFF;
			tmr_r   <= '0;
		end else begin
			case (state_r)
				DV_OFF: begin
					state_r <= DV_INIT;
					tmr_r   <= '0;
				end
				DV_INIT: begin
					if (tmr_r == 16'(INIT_N - 1))
						state_r <= DV_RUN;
					else
						tmr_r <= tmr_r + 16'h0001;
				end
				DV_RUN: begin
					if (clk_chg) begin
						state_r <= DV_RESYNC;
						tmr_r   <= '0;
					end
				end
				DV_RESYNC: begin
					if (tmr_r == 16'(RESYNC_N - 1))
						state_r <= DV_RUN;
					else
						tmr_r <= tmr_r + 16'h0001;
				end
				default: state_r <= DV_OFF;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// write capture
	// ----------------------------------------------------------------
	// data is held while the strobe is low, used at its release
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_prev_r <= 1'b1;
			wsel_r    <= 1'b0;
			wdat_r    <= '0;
			wadr_r    <= '0;
		end else begin
			wr_prev_r <= lnk.wr_n;
			if (!lnk.wr_n) begin
				wsel_r <= !lnk.cs_n;
				wdat_r <= lnk.data;
				wadr_r <= lnk.addr;
			end
		end
	end

	// ----------------------------------------------------------------
	// index and control registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			index_r <= '0;
			mce_r   <= 1'b0;
		end else if (state_r == DV_INIT) begin
			index_r <= '0;
			mce_r   <= 1'b0;
		end else if (wr_ok && wadr_r == A_INDEX) begin
			index_r <= wdat_r[3:0];
			mce_r   <= wdat_r[IDX_MCE_BIT];
		end
	end

	// clock format only changes inside the mode-change window or at the init-end default load
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < 16; i++)
				ctrl_r[i] <= reg_default(4'(i));
		end else if (state_r == DV_INIT && tmr_r == 16'(INIT_N - 1)) begin
			for (int i = 0; i < 16; i++)
				ctrl_r[i] <= reg_default(4'(i));
		end else if (wr_ok && wadr_r == A_DATA && index_r != R_TEST
			&& (index_r != R_FMT || mce_r)) begin
			ctrl_r[index_r] <= wdat_r;
		end
	end

	// ----------------------------------------------------------------
	// calibration
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			rate_chg_r <= 1'b0;
		else if (pd)
			rate_chg_r <= 1'b0;
		else if (clk_chg)
			rate_chg_r <= 1'b1;
		else if (cal_end)
			rate_chg_r <= 1'b0; // kept past mode-change exit for the short run
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cal_r     <= CL_IDLE;
			cal_cnt_r <= '0;
		end else if (pd) begin
			cal_r     <= CL_IDLE;
			cal_cnt_r <= '0;
		end else begin
			case (cal_r)
				CL_IDLE: begin
					if (mce_fall && ctrl_r[R_IFC][IFC_AUTOCAL_REQUEST_BIT]) begin
						cal_r     <= CL_WAIT;
						cal_cnt_r <= '0;
					end
				end
				CL_WAIT: begin
					if (o_sample_tick) begin
						if (cal_cnt_r == CAL_RISE_SP - 9'h001) begin
							cal_r     <= CL_RUN;
							cal_cnt_r <= '0;
						end else
							cal_cnt_r <= cal_cnt_r + 9'h001;
					end
				end
				CL_RUN: begin
					if (o_sample_tick) begin
						if (cal_cnt_r == cal_last - 9'h001)
							cal_r <= CL_IDLE;
						else
							cal_cnt_r <= cal_cnt_r + 9'h001;
					end
				end
				default: cal_r <= CL_IDLE;
			endcase
		end
	end

	// offsets change only at the end of a calibration run
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_offset <= '0;
		else if (cal_end)
			o_offset <= i_adc_offset;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			oe_r <= 1'b0;
			rd_r <= ZERO_BYTE;
		end else begin
			oe_r <= !pd && state_r != DV_OFF && !lnk.cs_n
				&& !lnk.rd_n;
			if (!run)
				rd_r <= BUSY_BYTE;
			else if (lnk.addr == A_INDEX)
				rd_r <= {1'b0, mce_r, 2'b00, index_r};
			else if (lnk.addr == A_DATA)
				rd_r <= index_r == R_TEST
					? 8'(autocal_in_progress) << TEST_ACI_BIT : ctrl_r[index_r];
			else if (lnk.addr == A_STATUS)
				rd_r <= {7'h00, autocal_in_progress};
			else
				rd_r <= ZERO_BYTE;
		end
	end

	assign lnk.d_oe   = oe_r;
	assign lnk.d_data = rd_r;

	// ----------------------------------------------------------------
	// sample strobe and converter side
	// ----------------------------------------------------------------
	cics_rate_gen u_rate (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_run      (run),
		.i_css      (ctrl_r[R_FMT][FMT_CSS_BIT]),
		.i_cfs      (ctrl_r[R_FMT][FMT_CFS_LSB +: 3]),
		.o_tick     (o_sample_tick)
	);

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_analog_en     <= 1'b0;
			o_dac_mute      <= 1'b1;
			o_capture_valid <= 1'b0;
			o_xfer_go       <= 1'b0;
			o_dac_data      <= '0;
		end else begin
			o_analog_en     <= !pd && state_r != DV_OFF;
			o_dac_mute      <= !run || !cal_idle;
			o_capture_valid <= run && cal_idle && o_sample_tick;
			o_xfer_go       <= run && cal_idle
				&& (ctrl_r[R_IFC][IFC_PEN_BIT]
				|| ctrl_r[R_IFC][IFC_CEN_BIT]);
			if (i_play_valid && run && cal_idle)
				o_dac_data <= i_play_data;
		end
	end
endmodule

// file: src/cics_host.sv
// host-side power-up, calibration and rate-change sequencer
`timescale 1ns/1ps
module cics_host
	import cics_pkg::*;
#(
	parameter int SETTLE_N = SETTLE_CYC,
	parameter int STB_N    = STB_CYC
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_b,
	cics_link_if.host       lnk,
	input  wire logic       i_power_on,
	input  wire logic       i_cmd_valid,
	input  wire logic       i_cmd_rate,
	input  wire logic       i_css,
	input  wire logic [2:0] i_cfs,
	output logic            o_ready,
	output logic            o_done
);
	typedef enum logic [2:0] {
		H_OFF    = 3'b000,
		H_INIT   = 3'b001,
		H_SETTLE = 3'b010,
		H_SEQ    = 3'b011,
		H_IDLE   = 3'b100
	} cics_host_st_t;

	typedef enum logic [1:0] {
		B_SETUP = 2'b00,
		B_STB   = 2'b01,
		B_HOLD  = 2'b10
	} cics_bus_ph_t;

	localparam logic [4:0] STEP_LAST = 5'd18;

	cics_host_st_t hst_r;
	cics_bus_ph_t  ph_r;
	logic [4:0]    step_r;
	logic [23:0]   cnt_r;
	logic [3:0]    stb_cnt_r;
	logic [7:0]    rdat_r;
	logic          rate_r;
	logic [7:0]    fmt_r;
	logic          pd_n_r;
	logic          cs_n_r;
	logic          rd_n_r;
	logic          wr_n_r;
	logic [1:0]    addr_r;
	logic [7:0]    hdat_r;
	logic          hoe_r;
	logic          active;
	logic          op_done;
	cics_op_t      op;

	// one bus cycle per step, repeated until a poll is met; steps 0 and 9 are the not-busy polls
	function automatic cics_op_t step_op(input logic [4:0] s,
		input logic rate, input logic [7:0] fmt);
		case (s)
			5'd1:  return '{OP_WR, A_INDEX, 8'(R_AUX1)};
			5'd2:  return '{OP_WR, A_DATA, MUTE_BYTE};
			5'd3:  return '{OP_WR, A_INDEX, 8'(R_AUX2)};
			5'd4:  return '{OP_WR, A_DATA, MUTE_BYTE};
			5'd5:  return '{OP_WR, A_INDEX, 8'(R_MIX)};
			5'd6:  return '{OP_WR, A_DATA, ZERO_BYTE};
			5'd7:  return '{OP_WR, A_INDEX,
				MCE_FLAG | 8'(rate ? R_FMT : R_IFC)};
			// playback enabled now; the device holds it off from the index write that ends mode change (step 10) until cal ends
			5'd8:  return '{OP_WR, A_DATA,
				rate ? fmt : DEF_IFC | (8'h01 << IFC_AUTOCAL_REQUEST_BIT)
				| (8'h01 << IFC_PEN_BIT)};
			5'd10: return '{OP_WR, A_INDEX, 8'(R_TEST)};
			5'd11: return '{OP_HI, A_DATA, ZERO_BYTE};
			5'd12: return '{OP_LO, A_DATA, ZERO_BYTE};
			5'd13: return '{OP_WR, A_INDEX, 8'(R_AUX1)};
			5'd14: return '{OP_WR, A_DATA, ZERO_BYTE};
			5'd15: return '{OP_WR, A_INDEX, 8'(R_AUX2)};
			5'd16: return '{OP_WR, A_DATA, ZERO_BYTE};
			5'd17: return '{OP_WR, A_INDEX, 8'(R_MIX)};
			5'd18: return '{OP_WR, A_DATA, MIX_ON};
			default: return '{OP_NE80, A_INDEX, ZERO_BYTE};
		endcase
	endfunction

	assign op      = step_op(step_r, rate_r, fmt_r);
	assign active  = (hst_r == H_INIT || hst_r == H_SEQ) && i_power_on;
	assign op_done = ph_r == B_HOLD && (op.kind == OP_WR
		|| (op.kind == OP_NE80 && rdat_r != BUSY_BYTE)
		|| (op.kind == OP_HI && rdat_r[TEST_ACI_BIT])
		|| (op.kind == OP_LO && !rdat_r[TEST_ACI_BIT]));

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hst_r  <= H_OFF;
			step_r <= '0;
			cnt_r  <= '0;
			rate_r <= 1'b0;
			fmt_r  <= '0;
		end else if (!i_power_on) begin
			hst_r <= H_OFF;
		end else begin
			case (hst_r)
				H_OFF: begin
					hst_r  <= H_INIT;
					step_r <= '0;
				end
				H_INIT: begin
					if (op_done) begin
						hst_r <= H_SETTLE;
						cnt_r <= '0;
					end
				end
				H_SETTLE: begin
					if (cnt_r == 24'(SETTLE_N - 1)) begin
						hst_r  <= H_SEQ;
						step_r <= 5'd1;
						rate_r <= 1'b0;
					end else
						cnt_r <= cnt_r + 24'h00_0001;
				end
				H_SEQ: begin
					if (op_done) begin
						if (step_r == STEP_LAST)
							hst_r <= H_IDLE;
						else
							step_r <= step_r + 5'd1;
					end
				end
				H_IDLE: begin
					if (i_cmd_valid) begin
						hst_r  <= H_SEQ;
						step_r <= 5'd1;
						rate_r <= i_cmd_rate;
						fmt_r  <= {4'h0, i_cfs, i_css};
					end
				end
				default: hst_r <= H_OFF;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ph_r   <= B_SETUP;
			cs_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			addr_r <= '0;
			hdat_r <= '0;
			hoe_r  <= 1'b0;
			rdat_r <= '0;
		end else if (!active) begin
			ph_r   <= B_SETUP;
			cs_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			hoe_r  <= 1'b0;
		end else begin
			case (ph_r)
				B_SETUP: begin
					cs_n_r <= 1'b0;
					addr_r <= op.addr;
					hdat_r <= op.data;
					hoe_r  <= op.kind == OP_WR;
					rd_n_r <= op.kind == OP_WR;
					wr_n_r <= op.kind != OP_WR;
					ph_r   <= B_STB;
				end
				B_STB: begin
					if (stb_cnt_r == 4'(STB_N - 1)) begin
						rdat_r <= lnk.data;
						rd_n_r <= 1'b1;
						wr_n_r <= 1'b1;
						ph_r   <= B_HOLD;
					end
				end
				B_HOLD: begin
					cs_n_r <= 1'b1;
					hoe_r  <= 1'b0;
					ph_r   <= B_SETUP;
				end
				default: ph_r <= B_SETUP;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			stb_cnt_r <= '0;
		else if (ph_r != B_STB)
			stb_cnt_r <= '0;
		else
			stb_cnt_r <= stb_cnt_r + 4'h1;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pd_n_r  <= 1'b0;
			o_ready <= 1'b0;
			o_done  <= 1'b0;
		end else begin
			pd_n_r  <= i_power_on;
			o_ready <= hst_r == H_IDLE && i_power_on;
			o_done  <= hst_r == H_SEQ && op_done && step_r == STEP_LAST;
		end
	end

	assign lnk.power_down_n = pd_n_r;
	assign lnk.cs_n         = cs_n_r;
	assign lnk.rd_n         = rd_n_r;
	assign lnk.wr_n         = wr_n_r;
	assign lnk.addr         = addr_r;
	assign lnk.h_data       = hdat_r;
	assign lnk.h_oe         = hoe_r;
endmodule

// file: src/cics_link_if.sv
// host bus between the codec sequencer and its host
`timescale 1ns/1ps
interface cics_link_if;
	logic       power_down_n;
	logic       cs_n;
	logic       rd_n;
	logic       wr_n;
	logic [1:0] addr;
	logic [7:0] h_data;
	logic       h_oe;
	logic [7:0] d_data;
	logic       d_oe;
	logic [7:0] data;

	// resolved data lines; an undriven bus floats high
	assign data = d_oe ? d_data : (h_oe ? h_data : cics_pkg::IDLE_BYTE);

	modport dev (
		input  power_down_n, cs_n, rd_n, wr_n, addr, data,
		output d_data, d_oe
	);
	modport host (
		output power_down_n, cs_n, rd_n, wr_n, addr, h_data, h_oe,
		input  data
	);
endinterface

// file: src/cics_pkg.sv
// shared constants, types and helpers for the codec init/calibration link
// Overview of operation
// - power-down low stops device and its bus
// - bus data lines released during power-down
// - init phase: writes dropped, reads give 80h
// - init end loads control register defaults
// - host polls index until not 80h
// - host releases power-down, then waits one second
// - leaving mode change with request starts calibration
// - no request keeps stored offsets unchanged
// - flag rises within five, lasts 384 samples
// - transfers held back until calibration ends
// - playback ignored, capture meaningless during calibration
// - playback outputs muted automatically while calibrating
// - host calibration steps in fixed order
// - rate change: mode change, then one write
// - resync after clock change: busy like init
// - calibration after rate change lasts 128 samples
// - host calibrates after every power-up
package cics_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ    = 10;
	localparam int SETTLE_US  = 1_000_000;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int INIT_CYC   = 64;
	localparam int RESYNC_CYC = 32;
	localparam int STB_CYC    = 4;
	localparam logic [8:0] CAL_RISE_SP = 9'h003;
	localparam logic [8:0] CAL_FULL_SP = 9'h180;
	localparam logic [8:0] CAL_RATE_SP = 9'h080;
	localparam logic [11:0] SP_BASE = 12'h0d0;
	localparam logic [11:0] SP_STEP = 12'h0c0;

	// ----------------------------------------------------------------
	// bus addresses, indices, fields, values
	// ----------------------------------------------------------------
	localparam logic [1:0] A_INDEX  = 2'h0;
	localparam logic [1:0] A_DATA   = 2'h1;
	localparam logic [1:0] A_STATUS = 2'h2;
	localparam logic [3:0] R_AUX1 = 4'h2;
	localparam logic [3:0] R_AUX2 = 4'h4;
	localparam logic [3:0] R_FMT  = 4'h8;
	localparam logic [3:0] R_IFC  = 4'h9;
	localparam logic [3:0] R_TEST = 4'hb;
	localparam logic [3:0] R_MIX  = 4'hd;
	localparam int IDX_MCE_BIT  = 6;
	localparam int IFC_PEN_BIT  = 0;
	localparam int IFC_CEN_BIT  = 1;
	localparam int IFC_AUTOCAL_REQUEST_BIT = 3;
	localparam int TEST_ACI_BIT = 5;
	localparam int FMT_CSS_BIT  = 0;
	localparam int FMT_CFS_LSB  = 1;
	localparam logic [7:0] BUSY_BYTE = 8'h80;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	localparam logic [7:0] MCE_FLAG  = 8'h40;
	localparam logic [7:0] MUTE_BYTE = 8'h80;
	localparam logic [7:0] MIX_ON    = 8'h01;
	localparam logic [7:0] DEF_IFC   = 8'h08;
	localparam logic [7:0] DEF_AUX   = 8'h80;
	localparam logic [7:0] DEF_MIX   = 8'h00;
	localparam logic [7:0] DEF_OTHER = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DV_OFF    = 2'b00,
		DV_INIT   = 2'b01,
		DV_RUN    = 2'b10,
		DV_RESYNC = 2'b11
	} cics_dev_st_t;

	typedef enum logic [1:0] {
		CL_IDLE = 2'b00,
		CL_WAIT = 2'b01,
		CL_RUN  = 2'b10
	} cics_cal_st_t;

	typedef enum logic [1:0] {
		OP_WR   = 2'b00,
		OP_NE80 = 2'b01,
		OP_HI   = 2'b10,
		OP_LO   = 2'b11
	} cics_kind_t;

	typedef struct packed {
		cics_kind_t  kind;
		logic [1:0]  addr;
		logic [7:0]  data;
	} cics_op_t;

	// sample period in core clocks; source select doubles it
	function automatic logic [11:0] sp_period(input logic clock_source_select,
		input logic [2:0] cfs);
		logic [11:0] p;
		p = SP_BASE + 12'(cfs) * SP_STEP;
		return clock_source_select ? {p[10:0], 1'b0} : p;
	endfunction

	function automatic logic [7:0] reg_default(input logic [3:0] i);
		if (i == R_IFC)
			return DEF_IFC;
		else if (i == R_AUX1 || i == R_AUX2)
			return DEF_AUX;
		else if (i == R_MIX)
			return DEF_MIX;
		else
			return DEF_OTHER;
	endfunction

endpackage

// file: src/cics_rate_gen.sv
// sample-period strobe generator
`timescale 1ns/1ps
module cics_rate_gen
	import cics_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_run,
	input  wire logic       i_css,
	input  wire logic [2:0] i_cfs,
	output logic            o_tick
);
	logic [11:0] cnt_r;
	logic [11:0] last;

	assign last = sp_period(i_css, i_cfs) - 12'h001;

	// stopping the count on !i_run restarts the phase on the new clock
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			cnt_r <= '0;
		else if (!i_run || cnt_r == last)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 12'h001;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_tick <= 1'b0;
		else
			o_tick <= i_run && cnt_r == last;
	end
endmodule

// file: test/cics_props.sv
// assertions on the host link of the codec sequencer
`timescale 1ns/1ps
module cics_props
	import cics_pkg::*;
#(
	parameter int INIT_N = INIT_CYC,
	parameter int STB_N  = STB_CYC
) (
	input wire logic       i_core_clk,
	input wire logic       i_rst_b,
	input wire logic       power_down_n,
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [1:0] addr,
	input wire logic [7:0] h_data,
	input wire logic       h_oe,
	input wire logic [7:0] d_data,
	input wire logic       d_oe,
	input wire logic [7:0] data
);
	logic [15:0] up_cnt_r;
	logic [3:0]  wlen_r;
	logic [3:0]  idx_r;
	logic        mce_r;
	logic [3:0]  fmt_r;
	logic        wr_q_r;
	logic        wr_tk;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	// ----------------------------------------------------------------
	// helper state: shadow of what the host has written
	// ----------------------------------------------------------------
	assign wr_tk = wr_n && !wr_q_r && !cs_n;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			up_cnt_r <= '0;
		else if (!power_down_n)
			up_cnt_r <= '0;
		else if (up_cnt_r != 16'hffff)
			up_cnt_r <= up_cnt_r + 16'h0001;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wlen_r <= '0;
			wr_q_r <= 1'b1;
		end else begin
			wlen_r <= wr_n ? 4'h0 : wlen_r + 4'h1;
			wr_q_r <= wr_n;
		end
	end

	// register defaults return at init end after power-down, so the shadow follows
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			idx_r <= '0;
			mce_r <= 1'b0;
			fmt_r <= DEF_OTHER[3:0];
		end else if (!power_down_n) begin
			idx_r <= '0;
			mce_r <= 1'b0;
			fmt_r <= DEF_OTHER[3:0];
		end else if (wr_tk && addr == A_INDEX) begin
			idx_r <= data[3:0];
			mce_r <= data[IDX_MCE_BIT];
		end else if (wr_tk && addr == A_DATA && idx_r == R_FMT && mce_r) begin
			fmt_r <= data[3:0];
		end
	end

	// ----------------------------------------------------------------
	// sequences and properties
	// ----------------------------------------------------------------
	sequence wr_taken;
		wr_tk;
	endsequence

	sequence rate_wr;
		wr_taken ##0 (addr == A_DATA && idx_r == R_FMT && mce_r
			&& data[3:0] != fmt_r);
	endsequence

	pd_float_a: assert property (!power_down_n |-> !d_oe)
		else $error("device drives bus in power-down");
	no_fight_a: assert property (!(d_oe && h_oe))
		else $error("both ends drive the data lines");
	init_busy_a: assert property (
		(d_oe && up_cnt_r < 16'(INIT_N - 2)) |-> d_data == BUSY_BYTE)
		else $error("read during init not busy byte");
	read_ans_a: assert property (
		(power_down_n && !cs_n && !rd_n) ##1 power_down_n |-> d_oe)
		else $error("read not answered");
	read_only_a: assert property (d_oe |-> !$past(cs_n) && !$past(rd_n))
		else $error("device drives without a read");
	strobe_cs_a: assert property ((!wr_n || !rd_n) |-> !cs_n)
		else $error("strobe without chip select");
	strobe_len_a: assert property ($rose(wr_n) |-> wlen_r == STB_N)
		else $error("write strobe length wrong");
	resync_busy_a: assert property (
		rate_wr |-> ##[1:12] (d_oe && d_data == BUSY_BYTE))
		else $error("no busy byte after clock change");
	index_poll_a: assert property (
		rate_wr |-> ##[1:12] (!cs_n && !rd_n && addr == A_INDEX))
		else $error("host does not poll index after rate write");
endmodule

// file: test/cics_tb.sv
// self-checking bench joining both ends of the codec sequencer link
`timescale 1ns/1ps
module cics_tb;
	import cics_pkg::*;

	localparam logic [2:0]  NEW_CFS = 3'h1;
	localparam logic [31:0] EXP_SP  = 32'h00d0 + 32'(NEW_CFS) * 32'h00c0;

	logic        i_core_clk;
	logic        i_rst_b;
	logic        power_on;
	logic        cmd_valid;
	logic        cmd_rate;
	logic        clock_source_select;
	logic [2:0]  cfs;
	logic [15:0] play_data;
	logic        play_valid;
	logic [15:0] adc_off;
	logic [15:0] dac_data;
	logic        dac_mute;
	logic        cap_valid;
	logic        xfer_go;
	logic [15:0] offset;
	logic        analog_en;
	logic        tick;
	logic        ready;
	logic        done;
	logic [15:0] off0;
	logic [15:0] prev_d;
	logic [1:0]  mute_h;
	logic        in_win;
	logic        tick_q;
	logic        span_ok;
	int          miss_pu;
	int          failures;
	int          checked;
	int          miss;
	int          ncyc;
	int          last_t;
	int          gap;
	int          n;

	cics_link_if lnk();

	cics_dev #(.INIT_N(INIT_CYC), .RESYNC_N(RESYNC_CYC)) i_cics_dev (
		.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .lnk(lnk),
		.i_play_data(play_data), .i_play_valid(play_valid),
		.i_adc_offset(adc_off), .o_dac_data(dac_data),
		.o_dac_mute(dac_mute), .o_capture_valid(cap_valid),
		.o_xfer_go(xfer_go), .o_offset(offset),
		.o_analog_en(analog_en), .o_sample_tick(tick));

	// settle time cut short so the run stays brief
	cics_host #(.SETTLE_N(100), .STB_N(STB_CYC)) i_cics_host (
		.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .lnk(lnk),
		.i_power_on(power_on), .i_cmd_valid(cmd_valid),
		.i_cmd_rate(cmd_rate), .i_css(clock_source_select), .i_cfs(cfs),
		.o_ready(ready), .o_done(done));

	cics_props #(.INIT_N(INIT_CYC), .STB_N(STB_CYC)) i_cics_props (
		.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
		.power_down_n(lnk.power_down_n), .cs_n(lnk.cs_n),
		.rd_n(lnk.rd_n), .wr_n(lnk.wr_n), .addr(lnk.addr),
		.h_data(lnk.h_data), .h_oe(lnk.h_oe), .d_data(lnk.d_data),
		.d_oe(lnk.d_oe), .data(lnk.data));

	initial i_core_clk = 1'b0;
	always #50 i_core_clk = ~i_core_clk;

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wait_tick;
		n = 0;
		do begin
			@(negedge i_core_clk);
			n++;
		end while (!tick && n < 2000);
		#1;
	endtask

	// ----------------------------------------------------------------
	// playback stream and sample monitor
	// ----------------------------------------------------------------
	always @(negedge i_core_clk) begin
		play_data <= play_data + 16'h0001;
		mute_h <= {mute_h[0], dac_mute};
		prev_d <= dac_data;
		ncyc <= ncyc + 1;
		tick_q <= tick;
		if (dac_mute && mute_h == 2'b11)
			check("frozen playback", 32'(dac_data), 32'(prev_d));
		if (tick) begin
			gap <= ncyc - last_t;
			last_t <= ncyc;
		end
		// capture pulse trails the tick by a cycle; a missing one means cal
		if (tick_q && in_win && !cap_valid) begin
			miss <= miss + 1;
			if (miss == miss_pu + 64) begin
				check("offset in cal", 32'(offset), 32'(off0));
				check("held transfer", 32'(xfer_go), 32'h0);
				check("cal mute", 32'(dac_mute), 32'h1);
			end
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		i_rst_b = 1'b0;
		power_on = 1'b0;
		cmd_valid = 1'b0;
		cmd_rate = 1'b0;
		clock_source_select = 1'b0;
		cfs = 3'h0;
		play_data = 16'h0000;
		play_valid = 1'b1;
		adc_off = 16'h1234;
		{failures, checked, miss, ncyc, last_t, gap, miss_pu} = '0;
		{off0, prev_d, mute_h, in_win, tick_q, span_ok} = '0;
		repeat (4) @(negedge i_core_clk);
		i_rst_b = 1'b1;
		repeat (4) @(negedge i_core_clk);
		check("analog off", 32'(analog_en), 32'h0);
		check("bus float", 32'(lnk.data), 32'(IDLE_BYTE));
		power_on = 1'b1;
		in_win = 1'b1;
		repeat (4) @(negedge i_core_clk);
		check("analog on", 32'(analog_en), 32'h1);
		n = 0;
		while (!ready && n < 100000) begin
			@(negedge i_core_clk);
			n++;
		end
		check("ready", 32'(ready), 32'h1);
		check("first offset", 32'(offset), 32'h1234);
		span_ok = miss >= 384 && miss <= 389;
		check("power-up cal span", 32'(span_ok), 32'h1);
		miss_pu = miss;
		off0 = offset;
		adc_off = 16'h5a5a;
		cfs = NEW_CFS;
		cmd_rate = 1'b1;
		cmd_valid = 1'b1;
		@(negedge i_core_clk);
		cmd_valid = 1'b0;
		n = 0;
		while (!done && n < 100000) begin
			@(negedge i_core_clk);
			n++;
		end
		in_win = 1'b0;
		check("done", 32'(done), 32'h1);
		check("new offset", 32'(offset), 32'h5a5a);
		span_ok = miss - miss_pu >= 128 && miss - miss_pu <= 133;
		check("rate cal span", 32'(span_ok), 32'h1);
		repeat (4) @(negedge i_core_clk);
		check("unmuted", 32'(dac_mute), 32'h0);
		check("transfer resumes", 32'(xfer_go), 32'h1);
		wait_tick();
		wait_tick();
		check("sample period", 32'(gap), EXP_SP);
		power_on = 1'b0;
		repeat (4) @(negedge i_core_clk);
		check("analog down", 32'(analog_en), 32'h0);
		check("dev released", 32'(lnk.d_oe), 32'h0);
		close_out();
	end

	// power-up cal plus the rate-change cal fit well inside this span
	initial begin
		repeat (300000) @(posedge i_core_clk);
		failures++;
		close_out();
	end
endmodule
